// ---- grouped_kill_pkg.sv ----
package grouped_kill_pkg;

  // -----------------------------------------------------------------
  // command codes and register layout
  // -----------------------------------------------------------------
  localparam logic [7:0] CMD_TEST_ENABLE = 8'h1D;
  localparam logic [7:0] CMD_GROUP_CFG = 8'h22;
  localparam logic [7:0] UNLOCK_CODE = 8'hBC;
  localparam logic [7:0] LOCK_CODE = 8'h00;
  localparam logic [7:0] TEST_ENABLE_RESET = 8'h00;
  localparam int CFG_WIDTH = 5;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam int CFG_KILL_EN_BIT = 4;
  localparam int CFG_SELECT_LSB = 0;
  localparam logic [7:0] READ_FILL = 8'h00;

  // -----------------------------------------------------------------
  // serial bus addressing and framing
  // -----------------------------------------------------------------
  localparam logic [6:0] UNLOCKED_ADDR = 7'h20;
  localparam logic [2:0] ADDR_BASE_DEFAULT = 3'h2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int PORT_COUNT = 4;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_CMD   = 7'h04,
    ST_WDATA = 7'h08,
    ST_ACK   = 7'h10,
    ST_RDATA = 7'h20,
    ST_RACK  = 7'h40
  } bus_state_e;

endpackage

// ---- host_bus_model.sv ----
`timescale 1ns/10ps
module host_bus_model (
  // clock
  input wire logic clock,
  // serial bus
  output logic scl,
  output logic hostSda,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    hostSda = 1'b1;
  end
  task automatic ph();
    repeat (4) @(posedge clock);
  endtask
  task automatic start();
    hostSda <= 1'b1; ph(); scl <= 1'b1; ph(); hostSda <= 1'b0; ph(); scl <= 1'b0; ph();
  endtask
  // relock frames always close with a stop
  task automatic stop();
    hostSda <= 1'b0; ph(); scl <= 1'b1; ph(); hostSda <= 1'b1; ph();
  endtask
  // data moves only while clock is low
  task automatic bitx(input logic b, output logic r);
    hostSda <= b; ph(); scl <= 1'b1; ph(); r = sda; scl <= 1'b0; ph();
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic get(output logic [7:0] d, input logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nak, r);
  endtask
endmodule // host_bus_model

// ---- mux_shutdown_lock_control.sv ----
// Notes on behaviour
// - configuration register locked after power-up
// - writing BCh to test-enable unlocks configuration
// - unlocked device answers at fixed address 20h
// - lock code restores pin-selected slave address
// - enable set: shared input kills selected powered ports
// - enable clear: shared input kills port 1 only
// - per-port select bits choose affected ports
// - command 22h accesses configuration, reset zero
// - command 1Dh accesses test-enable code, reset zero
`timescale 1ns/10ps
module mux_shutdown_lock_control #(
  parameter logic [2:0] ADDR_BASE = grouped_kill_pkg::ADDR_BASE_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // two-wire serial bus
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // address select pins
  input wire logic [3:0] addrSelect,
  // shutdown inputs
  input wire logic firstPortOffInputN,
  input wire logic port2OffInputN,
  input wire logic port3OffInputN,
  input wire logic port4OffInputN,
  // port power state and kill requests
  input wire logic [3:0] portPowered,
  output logic [3:0] portKill,
  // status
  output logic configUnlocked
);

  // -----------------------------------------------------------------
  // registers and lock state
  // -----------------------------------------------------------------
  logic [7:0] testEnable_r;
  logic [4:0] groupCfg_r;
  logic unlocked;
  logic [6:0] activeAddr;

  assign unlocked = (testEnable_r == grouped_kill_pkg::UNLOCK_CODE);
  assign configUnlocked = unlocked;
  assign activeAddr = unlocked ? grouped_kill_pkg::UNLOCKED_ADDR : {ADDR_BASE, addrSelect};

  // -----------------------------------------------------------------
  // bus line edge detection
  // -----------------------------------------------------------------
  logic sclPrev_r;
  logic sdaPrev_r;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= scl;
      sdaPrev_r <= sdaIn;
    end
  end

  assign sclRise = scl & ~sclPrev_r;
  assign sclFall = ~scl & sclPrev_r;
  assign startSeen = scl & sclPrev_r & sdaPrev_r & ~sdaIn;
  assign stopSeen = scl & sclPrev_r & ~sdaPrev_r & sdaIn;

  // -----------------------------------------------------------------
  // byte engine
  // -----------------------------------------------------------------
  grouped_kill_pkg::bus_state_e state_r;
  grouped_kill_pkg::bus_state_e afterAck_r;
  logic [3:0] bitCnt_r;
  logic [7:0] rxShift_r;
  logic [7:0] txShift_r;
  logic [7:0] cmd_r;
  logic masterAck_r;
  logic byteDone;
  logic [7:0] readValue;
  logic writeStrobe;

  assign byteDone = sclFall && (bitCnt_r == grouped_kill_pkg::BITS_PER_BYTE);
  assign writeStrobe = byteDone && (state_r == grouped_kill_pkg::ST_WDATA);

  always_comb begin
    unique case (cmd_r)
      grouped_kill_pkg::CMD_TEST_ENABLE: readValue = testEnable_r;
      grouped_kill_pkg::CMD_GROUP_CFG: readValue = {3'h0, groupCfg_r};
      default: readValue = grouped_kill_pkg::READ_FILL;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= grouped_kill_pkg::ST_IDLE;
      afterAck_r <= grouped_kill_pkg::ST_IDLE;
      bitCnt_r <= 4'h0;
      rxShift_r <= 8'h00;
      txShift_r <= 8'hFF;
      masterAck_r <= 1'b0;
    end else if (startSeen) begin
      state_r <= grouped_kill_pkg::ST_ADDR;
      bitCnt_r <= 4'h0;
    end else if (stopSeen) begin
      state_r <= grouped_kill_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        grouped_kill_pkg::ST_IDLE: begin
          bitCnt_r <= 4'h0;
        end
        grouped_kill_pkg::ST_ADDR, grouped_kill_pkg::ST_CMD, grouped_kill_pkg::ST_WDATA: begin
          if (sclRise) begin
            rxShift_r <= {rxShift_r[6:0], sdaIn};
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (byteDone) begin
            state_r <= grouped_kill_pkg::ST_ACK;
            if (state_r == grouped_kill_pkg::ST_ADDR) begin
              if (rxShift_r[7:1] != activeAddr) begin
                state_r <= grouped_kill_pkg::ST_IDLE;
              end
              afterAck_r <= rxShift_r[0] ? grouped_kill_pkg::ST_RDATA : grouped_kill_pkg::ST_CMD;
            end else begin
              afterAck_r <= grouped_kill_pkg::ST_WDATA;
            end
          end
        end
        grouped_kill_pkg::ST_ACK: begin
          if (sclFall) begin
            state_r <= afterAck_r;
            bitCnt_r <= 4'h0;
            txShift_r <= readValue;
          end
        end
        grouped_kill_pkg::ST_RDATA: begin
          if (sclFall) begin
            txShift_r <= {txShift_r[6:0], 1'b1};
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == grouped_kill_pkg::BITS_PER_BYTE - 4'h1) begin
              state_r <= grouped_kill_pkg::ST_RACK;
            end
          end
        end
        grouped_kill_pkg::ST_RACK: begin
          if (sclRise) begin
            masterAck_r <= ~sdaIn;
          end else if (sclFall) begin
            bitCnt_r <= 4'h0;
            txShift_r <= readValue;
            state_r <= masterAck_r ? grouped_kill_pkg::ST_RDATA : grouped_kill_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= grouped_kill_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // command capture
  // -----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_r <= 8'h00;
    end else if (byteDone && (state_r == grouped_kill_pkg::ST_CMD)) begin
      cmd_r <= rxShift_r;
    end
  end

  // -----------------------------------------------------------------
  // register writes
  // -----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      testEnable_r <= grouped_kill_pkg::TEST_ENABLE_RESET;
    end else if (writeStrobe && (cmd_r == grouped_kill_pkg::CMD_TEST_ENABLE)) begin
      testEnable_r <= rxShift_r;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      groupCfg_r <= grouped_kill_pkg::CFG_RESET;
    end else if (writeStrobe && (cmd_r == grouped_kill_pkg::CMD_GROUP_CFG) && unlocked) begin
      groupCfg_r <= rxShift_r[grouped_kill_pkg::CFG_WIDTH-1:0];
    end
  end

  // -----------------------------------------------------------------
  // open-drain data line
  // -----------------------------------------------------------------
  assign sdaOut = 1'b0;
  assign sdaOeN = ~((state_r == grouped_kill_pkg::ST_ACK) ||
                    ((state_r == grouped_kill_pkg::ST_RDATA) && ~txShift_r[7]));

  // -----------------------------------------------------------------
  // port shutdown
  // -----------------------------------------------------------------
  port_kill_logic #(
    .NPORTS(grouped_kill_pkg::PORT_COUNT)
  ) u_kill (
    .clock(clock),
    .sys_rst(sys_rst),
    .groupedKillEnable(groupCfg_r[grouped_kill_pkg::CFG_KILL_EN_BIT]),
    .groupedKillSelect(groupCfg_r[grouped_kill_pkg::CFG_SELECT_LSB +: grouped_kill_pkg::PORT_COUNT]),
    .offInputN({port4OffInputN, port3OffInputN, port2OffInputN, firstPortOffInputN}),
    .portPowered(portPowered),
    .portKill(portKill)
  );

endmodule // mux_shutdown_lock_control

// ---- mux_shutdown_lock_control_bench.sv ----
`timescale 1ns/10ps
module mux_shutdown_lock_control_bench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic firstPortOffInputN = 1'b1;
  logic [2:0] ownOffN = 3'h7;
  logic [3:0] addrSelect = 4'h5;
  logic [3:0] portPowered = 4'h0;
  logic scl, hostSda, sda, sdaOut, sdaOeN, configUnlocked, ack;
  logic [3:0] portKill;
  logic [6:0] pin;
  logic [7:0] rdata;
  int errors = 0;
  int n_tests = 0;
  assign sda = hostSda & (sdaOeN | sdaOut);
  assign pin = {grouped_kill_pkg::ADDR_BASE_DEFAULT, addrSelect};
  always #25 clock = ~clock;
  mux_shutdown_lock_control dut (.clock(clock), .sys_rst(sys_rst), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .addrSelect(addrSelect), .firstPortOffInputN(firstPortOffInputN),
    .port2OffInputN(ownOffN[0]), .port3OffInputN(ownOffN[1]), .port4OffInputN(ownOffN[2]),
    .portPowered(portPowered), .portKill(portKill), .configUnlocked(configUnlocked));
  host_bus_model host (.clock(clock), .scl(scl), .hostSda(hostSda), .sda(sda));
  // ----
  // access tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
    logic k;
    host.start();
    host.put({a, 1'b0}, ack);
    if (ack) begin
      host.put(c, k);
      host.put(d, k);
    end
    host.stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c);
    logic k;
    host.start();
    host.put({a, 1'b0}, k);
    host.put(c, k);
    host.start();
    host.put({a, 1'b1}, k);
    host.get(rdata, 1'b1);
    host.stop();
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    logic [4:0] cfgs [5] = '{5'h1F, 5'h15, 5'h1A, 5'h10, 5'h0E};
    logic [3:0] pws [5] = '{4'hF, 4'hF, 4'h7, 4'hF, 4'hB};
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    check(configUnlocked, 8'h00);
    rd(pin, grouped_kill_pkg::CMD_GROUP_CFG);
    check(rdata, 8'h00);
    rd(pin, grouped_kill_pkg::CMD_TEST_ENABLE);
    check(rdata, 8'h00);
    wr(pin, grouped_kill_pkg::CMD_GROUP_CFG, 8'h1F);
    rd(pin, grouped_kill_pkg::CMD_GROUP_CFG);
    check(rdata, 8'h00);
    wr(pin, grouped_kill_pkg::CMD_TEST_ENABLE, grouped_kill_pkg::UNLOCK_CODE);
    check(configUnlocked, 8'h01);
    rd(7'h20, grouped_kill_pkg::CMD_TEST_ENABLE);
    check(rdata, grouped_kill_pkg::UNLOCK_CODE);
    wr(pin, grouped_kill_pkg::CMD_TEST_ENABLE, grouped_kill_pkg::UNLOCK_CODE);
    check(ack, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(7'h20, grouped_kill_pkg::CMD_GROUP_CFG, {3'h0, cfgs[i]});
      check(ack, 8'h01);
      portPowered <= pws[i];
      firstPortOffInputN <= 1'b0;
      repeat (3) @(posedge clock);
      check(portKill, pws[i] & (cfgs[i][4] ? cfgs[i][3:0] : 4'h1));
      firstPortOffInputN <= 1'b1;
      repeat (3) @(posedge clock);
    end
    portPowered <= 4'hF;
    ownOffN <= 3'h5;
    repeat (3) @(posedge clock);
    check(portKill, 8'h04);
    ownOffN <= 3'h7;
    rd(7'h20, grouped_kill_pkg::CMD_GROUP_CFG);
    check(rdata, 8'h0E);
    wr(7'h20, grouped_kill_pkg::CMD_TEST_ENABLE, grouped_kill_pkg::LOCK_CODE);
    check(configUnlocked, 8'h00);
    wr(7'h20, grouped_kill_pkg::CMD_GROUP_CFG, 8'h1F);
    check(ack, 8'h00);
    wr(pin, grouped_kill_pkg::CMD_GROUP_CFG, 8'h1F);
    rd(pin, grouped_kill_pkg::CMD_GROUP_CFG);
    check(rdata, 8'h0E);
    // read again without a command phase, host acks the first byte
    host.start();
    host.put({pin, 1'b1}, ack);
    check(ack, 8'h01);
    host.get(rdata, 1'b0);
    check(rdata, 8'h0E);
    host.get(rdata, 1'b1);
    host.stop();
    check(rdata, 8'h0E);
    rd(pin, 8'h1E);
    check(rdata, grouped_kill_pkg::READ_FILL);
    wr(pin, grouped_kill_pkg::CMD_TEST_ENABLE, grouped_kill_pkg::UNLOCK_CODE);
    check(configUnlocked, 8'h01);
    wr(7'h20, grouped_kill_pkg::CMD_TEST_ENABLE, 8'h5A);
    check(configUnlocked, 8'h00);
    rd(pin, grouped_kill_pkg::CMD_TEST_ENABLE);
    check(rdata, 8'h5A);
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    wrap_up();
  end
endmodule // mux_shutdown_lock_control_bench
bind mux_shutdown_lock_control mux_shutdown_lock_control_chk chk (.clock(clock), .sys_rst(sys_rst), .scl(scl),
  .sdaOeN(sdaOeN), .firstPortOffInputN(firstPortOffInputN), .port2OffInputN(port2OffInputN),
  .port3OffInputN(port3OffInputN), .port4OffInputN(port4OffInputN), .portPowered(portPowered),
  .portKill(portKill), .configUnlocked(configUnlocked));

// ---- mux_shutdown_lock_control_chk.sv ----
`timescale 1ns/10ps
module mux_shutdown_lock_control_chk (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial bus
  input wire logic scl,
  input wire logic sdaOeN,
  // shutdown link
  input wire logic firstPortOffInputN,
  input wire logic port2OffInputN,
  input wire logic port3OffInputN,
  input wire logic port4OffInputN,
  input wire logic [3:0] portPowered,
  input wire logic [3:0] portKill,
  input wire logic configUnlocked
);
  // ----
  // assertions
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic allHigh;
  assign allHigh = firstPortOffInputN & port2OffInputN & port3OffInputN & port4OffInputN;
  sda_scl_low_a: assert property ($changed(sdaOeN) |-> !scl)
    else $error("data line moved while clock high");
  ack_hold_a: assert property ($fell(sdaOeN) |-> !sdaOeN [*4])
    else $error("pulled low too briefly");
  unlock_edge_a: assert property ($rose(configUnlocked) |-> !scl ##[0:1] !sdaOeN)
    else $error("unlock outside data byte end");
  relock_edge_a: assert property ($fell(configUnlocked) |-> !scl ##[0:1] !sdaOeN)
    else $error("relock outside data byte end");
  idle_no_kill_a: assert property ($past(allHigh) |-> portKill == 4'h0)
    else $error("kill without any low input");
  unpowered_safe_a: assert property ((portKill & ~$past(portPowered)) == 4'h0)
    else $error("kill on unpowered port");
  port1_cause_a: assert property (portKill[0] |-> $past(!firstPortOffInputN))
    else $error("port 1 kill without shared input");
  port2_cause_a: assert property (portKill[1] |-> $past(!firstPortOffInputN || !port2OffInputN))
    else $error("port 2 kill without cause");
  own_input_a: assert property ($past(!sys_rst && !port3OffInputN && portPowered[2]) |-> portKill[2])
    else $error("port 3 own input ignored");
  cover property ($rose(configUnlocked));
  cover property ($fell(configUnlocked));
  cover property (portKill == 4'hF);
endmodule // mux_shutdown_lock_control_chk

// ---- port_kill_logic.sv ----
`timescale 1ns/10ps
module port_kill_logic #(
  parameter int NPORTS = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // configuration
  input wire logic groupedKillEnable,
  input wire logic [NPORTS-1:0] groupedKillSelect,
  // shutdown inputs, index 0 is the first (shared) input
  input wire logic [NPORTS-1:0] offInputN,
  input wire logic [NPORTS-1:0] portPowered,
  // shutdown requests
  output logic [NPORTS-1:0] portKill
);

  // -----------------------------------------------------------------
  // per-port kill decision
  // -----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NPORTS; i++) begin : g_port
      logic grouped;
      logic own;
      if (i == 0) begin : g_first
        assign grouped = groupedKillEnable ? groupedKillSelect[i] : 1'b1;
        assign own = 1'b0;
      end else begin : g_other
        assign grouped = groupedKillEnable & groupedKillSelect[i];
        assign own = ~offInputN[i];
      end
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          portKill[i] <= 1'b0;
        end else begin
          portKill[i] <= portPowered[i] & ((~offInputN[0] & grouped) | own);
        end
      end
    end
  endgenerate

endmodule // port_kill_logic
